// [rtl/dci_defines.vh]
`ifndef DCI_DEFINES_VH
`define DCI_DEFINES_VH
// ---------------------------------------------
// register byte offsets
// ---------------------------------------------
`define DCI_CTRL_OFS 8'h00
`define DCI_STAT_OFS 8'h04
`define DCI_WPROT_OFS 8'h08
`define DCI_HEAD_OFS 8'h0C
`define DCI_PTR_OFS 8'h40
// ---------------------------------------------
// control code fields and byte commands
// ---------------------------------------------
`define DCI_CMD_HI 7
`define DCI_CMD_LO 4
`define DCI_BC_EXEC 4'h0
`define DCI_BC_PTR 4'h1
`define DCI_BC_RESTORE 4'h2
`define DCI_BC_WP_SET 4'h3
`define DCI_BC_WP_CLR 4'h4
// ---------------------------------------------
// status codes
// ---------------------------------------------
`define DCI_ST_OK 8'h01
`define DCI_ST_NO_DRV 8'hC2
`define DCI_ST_MULTI_DRV 8'hC3
`define DCI_ST_BAD_CMD 8'hC4
`define DCI_ST_BAD_TRK 8'hC5
`define DCI_ST_BAD_SEC 8'hC6
`define DCI_ST_BAD_BUF 8'hC7
`define DCI_ST_NOT_RDY 8'hA1
`define DCI_ST_SW_WP 8'hA3
`define DCI_ST_HW_CLASS 4'h9
`define DCI_ST_NO_TRK0 8'h91
`define DCI_BUF_ILLEGAL_HI 8'hE0
// ---------------------------------------------
// pointer array defaults and timing
// ---------------------------------------------
`define DCI_PTR0_RST 16'h0080
`define DCI_CLK_KHZ 20000
`define DCI_RESTORE_MS 500
`define DCI_SYNC_CYC 4
`define DCI_MAX_TRACK 76
`define DCI_MAX_SECTOR 26
`endif

// [rtl/dci_top.v]
// Implementation choices: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/100ps
`include "dci_defines.vh"
// Overview of operation
// [RL1] byte commands 3 and 4 update software write protect of selected drives
// [RL2] each low-nibble bit selects one drive; zero leaves it deselected
// [RL3] host calls standard or mini drive entry with control code in accumulator
// [RL4] pointer update: code 1x with index x starts three successive calls
// [RL5] second call gives low address byte, third gives high byte, stored
// [RL6] byte command 2 restores selected heads to track zero, positions tracked after
// [RL7] transfer error may trigger a head restore and retry before failing
// [RL8] host places a command string of four plus one or three bytes; code 3 fetches a string of four bytes only
// [RL9] host clears string byte two before the execute call
// [RL10] sixteen sixteen-bit pointer entries selected by a four-bit index
// [RL11] host starts a string with code 0 and pointer index
// [RL12] control byte arrives by a write to the command port
// [RL13] code 0x fetches the string at pointer entry x and executes it
// [RL14] parameters checked first; a bad string returns a distinct error at once
// [RL15] valid string: seek track, find sector, move data to or from buffer
// [RL16] status is reported only after success or unrecoverable error
// [RL17] same status goes to string byte two and the accumulator
// [RL18] success sets the status lsb
// [RL19] error sets the status msb with the condition in remaining bits
// [RL20] error also sets the sign flag
// [RL21] error class one-hot in bits 6..4, type in the low nibble
// [RL22] string errors Cx, operator errors Ax, hardware errors 9x
// [RL23] drive byte command selecting no drive is rejected with error
// [RL24] host issues no new code until the previous one has returned
// [RL25] pointer entries take defined defaults after reset
module dci_top #(
  parameter RESTORE_CYC = `DCI_RESTORE_MS * `DCI_CLK_KHZ,
  parameter MAX_TRACK = `DCI_MAX_TRACK,
  parameter MAX_SECTOR = `DCI_MAX_SECTOR
) (
  input wire ref_clk,
  input wire sys_rst,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  output reg mem_req,
  output reg mem_we,
  output reg [15:0] mem_addr,
  output reg [7:0] mem_wdata,
  input wire [7:0] mem_rdata,
  input wire mem_ack,
  output reg [3:0] drv_restore,
  input wire [3:0] drv_trk0,
  input wire [3:0] drv_ready,
  output reg xfer_go,
  output reg [3:0] xfer_cmd,
  output reg [3:0] xfer_drv,
  output reg [7:0] xfer_fmt,
  output reg [7:0] xfer_track,
  output reg [7:0] xfer_sector,
  output reg [15:0] xfer_addr,
  input wire xfer_done,
  input wire xfer_err,
  input wire [3:0] xfer_code
);
// ---------------------------------------------
// state encoding
// ---------------------------------------------
localparam S_IDLE = 6'h01;
localparam S_FETCH = 6'h02;
localparam S_CHECK = 6'h04;
localparam S_RESTORE = 6'h08;
localparam S_XFER = 6'h10;
localparam S_WSTAT = 6'h20;

reg [5:0] state_r;
reg [15:0] ptr_r [0:15];
reg [7:0] cs_r [0:6];
reg [2:0] idx_r;
reg [2:0] need_r;
reg [15:0] base_r;
reg [7:0] ctrl_r;
reg [7:0] status_r;
reg sign_r;
reg busy_r;
reg [1:0] ptr_phase_r;
reg [3:0] ptr_idx_r;
reg [3:0] wprot_r;
reg [7:0] head_r [0:3];
reg [3:0] rsel_r;
reg from_str_r;
reg retry_r;
reg [31:0] tmo_r;
reg [7:0] sy1_r;
reg [7:0] sy2_r;
reg [7:0] sy3_r;
reg [7:0] pin_r;
reg aw_hold_r;
reg w_hold_r;
reg [7:0] awaddr_r;
reg [31:0] wdata_r;
reg [3:0] wstrb_r;
integer i;

wire [3:0] trk0 = pin_r[3:0];
wire [3:0] rdy = pin_r[7:4];
wire [3:0] cs_cmd = cs_r[0][7:4];
wire [3:0] cs_drv = cs_r[0][3:0];
wire wr_fire = aw_hold_r & w_hold_r & ~s_axi_bvalid;
wire ctrl_wr = wr_fire & (awaddr_r == `DCI_CTRL_OFS) & wstrb_r[0];

function [1:0] drv_num;
  input [3:0] oh;
  begin
    drv_num = oh[3] ? 2'd3 : oh[2] ? 2'd2 : oh[1] ? 2'd1 : 2'd0;
  end
endfunction

// string length by command: format 4, verify 5, others 7
function [2:0] str_len;
  input [3:0] c;
  begin
    str_len = (c == 4'h3) ? 3'd4 : (c == 4'h4) ? 3'd5 : 3'd7;
  end
endfunction

// ---------------------------------------------
// pin synchronisers
// ---------------------------------------------
always @(posedge ref_clk) begin
  if (sys_rst) begin
    sy1_r <= 8'h00;
    sy2_r <= 8'h00;
    sy3_r <= 8'h00;
    pin_r <= 8'h00;
  end else begin
    sy1_r <= {drv_ready, drv_trk0};
    sy2_r <= sy1_r;
    sy3_r <= sy2_r;
    pin_r <= (~(sy2_r ^ sy3_r) & sy2_r) | ((sy2_r ^ sy3_r) & pin_r);
  end
end

// ---------------------------------------------
// axi4-lite slave
// ---------------------------------------------
assign s_axi_awready = ~aw_hold_r;
assign s_axi_wready = ~w_hold_r;
assign s_axi_arready = ~s_axi_rvalid;

always @(posedge ref_clk) begin
  if (sys_rst) begin
    aw_hold_r <= 1'b0;
    w_hold_r <= 1'b0;
    awaddr_r <= 8'h00;
    wdata_r <= 32'h0000_0000;
    wstrb_r <= 4'h0;
    s_axi_bvalid <= 1'b0;
    s_axi_bresp <= 2'b00;
    s_axi_rvalid <= 1'b0;
    s_axi_rresp <= 2'b00;
    s_axi_rdata <= 32'h0000_0000;
  end else begin
    if (s_axi_awvalid & ~aw_hold_r) begin
      aw_hold_r <= 1'b1;
      awaddr_r <= s_axi_awaddr;
    end
    if (s_axi_wvalid & ~w_hold_r) begin
      w_hold_r <= 1'b1;
      wdata_r <= s_axi_wdata;
      wstrb_r <= s_axi_wstrb;
    end
    if (wr_fire) begin
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (awaddr_r == `DCI_CTRL_OFS) ? 2'b00 : 2'b10;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
    if (s_axi_arvalid & ~s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= 2'b00;
      s_axi_rdata <= 32'h0000_0000;
      if (s_axi_araddr[7:6] == 2'b01 && s_axi_araddr[1:0] == 2'b00) begin
        s_axi_rdata <= {16'h0000, ptr_r[s_axi_araddr[5:2]]};
      end else begin
        case (s_axi_araddr)
          `DCI_CTRL_OFS: s_axi_rdata <= {24'h000000, ctrl_r};
          `DCI_STAT_OFS: s_axi_rdata <= {22'h000000, busy_r, sign_r, status_r};
          `DCI_WPROT_OFS: s_axi_rdata <= {28'h0000000, wprot_r};
          `DCI_HEAD_OFS: s_axi_rdata <= {head_r[3], head_r[2], head_r[1], head_r[0]};
          default: s_axi_rresp <= 2'b10;
        endcase
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
end

// ---------------------------------------------
// command engine
// ---------------------------------------------
always @(posedge ref_clk) begin
  if (sys_rst) begin
    state_r <= S_IDLE;
    for (i = 0; i < 16; i = i + 1) begin
      ptr_r[i] <= (i == 0) ? `DCI_PTR0_RST : {i[3:0], 12'h000}; // RL25
    end
    for (i = 0; i < 7; i = i + 1) begin
      cs_r[i] <= 8'h00;
    end
    for (i = 0; i < 4; i = i + 1) begin
      head_r[i] <= 8'h00;
    end
    idx_r <= 3'd0;
    need_r <= 3'd0;
    base_r <= 16'h0000;
    ctrl_r <= 8'h00;
    status_r <= 8'h00;
    sign_r <= 1'b0;
    busy_r <= 1'b0;
    ptr_phase_r <= 2'd0;
    ptr_idx_r <= 4'h0;
    wprot_r <= 4'h0;
    rsel_r <= 4'h0;
    from_str_r <= 1'b0;
    retry_r <= 1'b0;
    tmo_r <= 32'h0000_0000;
    mem_req <= 1'b0;
    mem_we <= 1'b0;
    mem_addr <= 16'h0000;
    mem_wdata <= 8'h00;
    drv_restore <= 4'h0;
    xfer_go <= 1'b0;
    xfer_cmd <= 4'h0;
    xfer_drv <= 4'h0;
    xfer_fmt <= 8'h00;
    xfer_track <= 8'h00;
    xfer_sector <= 8'h00;
    xfer_addr <= 16'h0000;
  end else begin
    xfer_go <= 1'b0;
    drv_restore <= 4'h0;
    case (state_r)
      S_IDLE: begin
        if (ctrl_wr & ~busy_r) begin // RL12 RL24
          ctrl_r <= wdata_r[7:0];
          sign_r <= 1'b0;
          if (ptr_phase_r == 2'd1) begin
            ptr_r[ptr_idx_r][7:0] <= wdata_r[7:0]; // RL5
            ptr_phase_r <= 2'd2;
          end else if (ptr_phase_r == 2'd2) begin
            ptr_r[ptr_idx_r][15:8] <= wdata_r[7:0]; // RL5
            ptr_phase_r <= 2'd0;
            status_r <= `DCI_ST_OK;
          end else begin
            case (wdata_r[`DCI_CMD_HI:`DCI_CMD_LO])
              `DCI_BC_EXEC: begin
                base_r <= ptr_r[wdata_r[3:0]]; // RL10 RL13
                mem_addr <= ptr_r[wdata_r[3:0]];
                mem_we <= 1'b0;
                mem_req <= 1'b1;
                idx_r <= 3'd0;
                need_r <= 3'd4;
                busy_r <= 1'b1;
                state_r <= S_FETCH;
              end
              `DCI_BC_PTR: begin
                ptr_idx_r <= wdata_r[3:0]; // RL4
                ptr_phase_r <= 2'd1;
              end
              `DCI_BC_RESTORE, `DCI_BC_WP_SET, `DCI_BC_WP_CLR: begin
                if (wdata_r[3:0] == 4'h0) begin
                  status_r <= `DCI_ST_NO_DRV; // RL23
                  sign_r <= 1'b1;
                end else if (wdata_r[7:4] == `DCI_BC_RESTORE) begin
                  rsel_r <= wdata_r[3:0]; // RL6
                  drv_restore <= wdata_r[3:0];
                  from_str_r <= 1'b0;
                  tmo_r <= 32'h0000_0000;
                  busy_r <= 1'b1;
                  state_r <= S_RESTORE;
                end else begin
                  if (wdata_r[7:4] == `DCI_BC_WP_SET) begin
                    wprot_r <= wprot_r | wdata_r[3:0]; // RL1 RL2
                  end else begin
                    wprot_r <= wprot_r & ~wdata_r[3:0]; // RL1 RL2
                  end
                  status_r <= `DCI_ST_OK;
                end
              end
              default: begin
                status_r <= `DCI_ST_BAD_CMD;
                sign_r <= 1'b1;
              end
            endcase
          end
        end
      end
      S_FETCH: begin
        if (mem_ack) begin
          cs_r[idx_r] <= mem_rdata;
          if (idx_r == 3'd0) begin
            need_r <= str_len(mem_rdata[7:4]);
          end
          if (idx_r == 3'd0 && (mem_rdata[7:4] == 4'h0 || mem_rdata[7:4] > 4'h5)) begin
            mem_req <= 1'b0;
            state_r <= S_CHECK;
          end else if (idx_r + 3'd1 >= ((idx_r == 3'd0) ? str_len(mem_rdata[7:4]) : need_r)) begin
            mem_req <= 1'b0;
            state_r <= S_CHECK;
          end else begin
            idx_r <= (idx_r == 3'd0) ? 3'd2 : idx_r + 3'd1;
            mem_addr <= base_r + ((idx_r == 3'd0) ? 16'h0002 : {13'h0000, idx_r} + 16'h0001);
          end
        end
      end
      S_CHECK: begin
        mem_wdata <= `DCI_ST_OK;
        state_r <= S_WSTAT;
        if (cs_cmd == 4'h0 || cs_cmd > 4'h5) begin
          mem_wdata <= `DCI_ST_BAD_CMD; // RL14 RL22
        end else if (cs_drv == 4'h0) begin
          mem_wdata <= `DCI_ST_NO_DRV; // RL14
        end else if ((cs_drv & (cs_drv - 4'h1)) != 4'h0) begin
          mem_wdata <= `DCI_ST_MULTI_DRV; // RL14
        end else if (cs_r[3] > MAX_TRACK) begin
          mem_wdata <= `DCI_ST_BAD_TRK; // RL14
        end else if (need_r > 3'd4 && (cs_r[4] == 8'h00 || cs_r[4] > MAX_SECTOR)) begin
          mem_wdata <= `DCI_ST_BAD_SEC; // RL14
        end else if (need_r == 3'd7 && cs_r[6] == `DCI_BUF_ILLEGAL_HI) begin
          mem_wdata <= `DCI_ST_BAD_BUF; // RL14
        end else if (~rdy[drv_num(cs_drv)]) begin
          mem_wdata <= `DCI_ST_NOT_RDY; // RL22
        end else if (wprot_r[drv_num(cs_drv)] && (cs_cmd == 4'h1 || cs_cmd == 4'h3
                     || cs_cmd == 4'h5)) begin
          mem_wdata <= `DCI_ST_SW_WP; // RL22
        end else begin
          xfer_go <= 1'b1; // RL15
          xfer_cmd <= cs_cmd;
          xfer_drv <= cs_drv;
          xfer_fmt <= cs_r[2];
          xfer_track <= cs_r[3];
          xfer_sector <= cs_r[4];
          xfer_addr <= {cs_r[6], cs_r[5]};
          retry_r <= 1'b0;
          state_r <= S_XFER;
        end
      end
      S_XFER: begin
        if (xfer_done) begin
          if (~xfer_err) begin
            head_r[drv_num(xfer_drv)] <= xfer_track; // RL6
            mem_wdata <= `DCI_ST_OK;
            state_r <= S_WSTAT;
          end else if (~retry_r) begin
            retry_r <= 1'b1; // RL7
            rsel_r <= xfer_drv;
            drv_restore <= xfer_drv;
            from_str_r <= 1'b1;
            tmo_r <= 32'h0000_0000;
            state_r <= S_RESTORE;
          end else begin
            mem_wdata <= {`DCI_ST_HW_CLASS, xfer_code}; // RL21 RL22
            state_r <= S_WSTAT;
          end
        end
      end
      S_RESTORE: begin
        tmo_r <= tmo_r + 32'h0000_0001;
        // track-zero pins lag by the synchroniser; a stale high must not end the restore
        if (tmo_r >= `DCI_SYNC_CYC && (trk0 & rsel_r) == rsel_r) begin
          for (i = 0; i < 4; i = i + 1) begin
            if (rsel_r[i]) begin
              head_r[i] <= 8'h00; // RL6
            end
          end
          if (from_str_r) begin
            xfer_go <= 1'b1; // RL7
            state_r <= S_XFER;
          end else begin
            status_r <= `DCI_ST_OK;
            busy_r <= 1'b0;
            state_r <= S_IDLE;
          end
        end else if (tmo_r >= RESTORE_CYC - 1) begin
          if (from_str_r) begin
            mem_wdata <= `DCI_ST_NO_TRK0;
            state_r <= S_WSTAT;
          end else begin
            status_r <= `DCI_ST_NO_TRK0; // RL19
            sign_r <= 1'b1; // RL20
            busy_r <= 1'b0;
            state_r <= S_IDLE;
          end
        end
      end
      S_WSTAT: begin
        mem_addr <= base_r + 16'h0001;
        mem_we <= 1'b1;
        mem_req <= 1'b1;
        if (mem_req & mem_ack) begin
          mem_req <= 1'b0;
          mem_we <= 1'b0;
          status_r <= mem_wdata; // RL16 RL17 RL18 RL19
          sign_r <= mem_wdata[7]; // RL20
          busy_r <= 1'b0;
          state_r <= S_IDLE;
        end
      end
      default: begin
        state_r <= S_IDLE;
      end
    endcase
  end
end

endmodule

// [verif/dci_props.sv]
`timescale 1ns/100ps
module dci_props #(
  parameter MAX_TRACK = 76
) (
  input wire ref_clk,
  input wire sys_rst,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [31:0] s_axi_rdata,
  input wire mem_req,
  input wire mem_we,
  input wire mem_ack,
  input wire [15:0] mem_addr,
  input wire [7:0] mem_wdata,
  input wire [3:0] drv_restore,
  input wire xfer_go,
  input wire [3:0] xfer_drv,
  input wire [7:0] xfer_track,
  input wire xfer_done,
  input wire xfer_err
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  wire st_wr = mem_req && mem_we;
  a_req_hold:
    assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_we))
    else $error("memory request dropped early");
  a_go_pulse:
    assert property (xfer_go |=> !xfer_go) else $error("transfer start not a pulse");
  a_go_legal:
    assert property (xfer_go |-> $onehot(xfer_drv) && xfer_track <= MAX_TRACK)
    else $error("transfer started with bad drive or track");
  a_restore_pulse:
    assert property (|drv_restore |=> drv_restore == 4'h0) else $error("restore not a pulse");
  a_status_form:
    assert property (st_wr |-> mem_wdata == 8'h01 || (mem_wdata[7] && $onehot(mem_wdata[6:4])))
    else $error("status code malformed");
  a_done_first:
    assert property (xfer_go |=> !st_wr throughout (##[0:40] xfer_done))
    else $error("status written before transfer end");
  a_err_recover:
    assert property (xfer_done && xfer_err |-> ##[1:40] (|drv_restore || (st_wr
      && mem_wdata[7:4] == 4'h9))) else $error("no recovery after transfer error");
  a_b_hold:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  a_r_hold:
    assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  cover property (xfer_done && xfer_err);
  cover property (st_wr && mem_wdata[7]);
  cover property (|drv_restore);
endmodule
bind dci_top dci_props #(.MAX_TRACK(MAX_TRACK)) dci_props_inst (.ref_clk, .sys_rst,
  .s_axi_bvalid, .s_axi_bready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .mem_req,
  .mem_we, .mem_ack, .mem_addr, .mem_wdata, .drv_restore, .xfer_go, .xfer_drv, .xfer_track,
  .xfer_done, .xfer_err);

// [verif/dci_far_model.sv]
`timescale 1ns/100ps
module dci_far_model (
  input wire ref_clk,
  input wire sys_rst,
  input wire mem_req,
  input wire mem_we,
  input wire [15:0] mem_addr,
  input wire [7:0] mem_wdata,
  output reg [7:0] mem_rdata,
  output reg mem_ack,
  input wire [3:0] drv_restore,
  output reg [3:0] drv_trk0,
  input wire [3:0] dead,
  input wire xfer_go,
  input wire [3:0] xfer_drv,
  output reg xfer_done,
  output reg xfer_err,
  output reg [3:0] xfer_code,
  input wire [1:0] fails,
  input wire [3:0] ecode,
  input wire slow
);
  reg [7:0] mem [0:65535];
  reg [3:0] mw_r, xw_r, rw_r, rm_r;
  reg [1:0] nf_r;
  always @(posedge ref_clk) begin
    mem_ack <= 1'b0;
    xfer_done <= 1'b0;
    xfer_err <= 1'b0;
    xfer_code <= ~xfer_code;
    mem_rdata <= ~mem_rdata;
    if (sys_rst) begin
      {mw_r, xw_r, rw_r, rm_r, nf_r, drv_trk0, mem_rdata, xfer_code} <= 34'h0;
    end else begin
      // memory answers promptly or slowly, data only with the ack
      if (mem_req && !mem_ack) begin
        mw_r <= mw_r + 4'h1;
        if (mw_r >= (slow ? 4'h5 : 4'h0)) begin
          mem_ack <= 1'b1;
          mw_r <= 4'h0;
          if (mem_we) begin
            mem[mem_addr] <= mem_wdata;
            nf_r <= 2'h0;
          end else begin
            mem_rdata <= mem[mem_addr];
          end
        end
      end
      // transfer engine fails the first fails attempts
      if (xfer_go) begin
        xw_r <= slow ? 4'h8 : 4'h2;
        drv_trk0 <= drv_trk0 & ~xfer_drv;
      end else if (xw_r != 4'h0) begin
        xw_r <= xw_r - 4'h1;
        if (xw_r == 4'h1) begin
          xfer_done <= 1'b1;
          if (nf_r < fails) begin
            xfer_err <= 1'b1;
            xfer_code <= ecode;
            nf_r <= nf_r + 2'h1;
          end
        end
      end
      // heads reach track zero a while after restore, dead drives never
      if (|drv_restore) begin
        rm_r <= drv_restore & ~dead;
        rw_r <= 4'h6;
      end else if (rw_r != 4'h0) begin
        rw_r <= rw_r - 4'h1;
        if (rw_r == 4'h1) drv_trk0 <= drv_trk0 | rm_r;
      end
    end
  end
endmodule

// [verif/dci_top_bench.sv]
`timescale 1ns/100ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_total++; \
  $display("Error t=%0t got %h exp %h", $time, a, b); end end
module dci_top_bench;
  reg ref_clk = 1'b0;
  reg sys_rst = 1'b1;
  reg [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  reg [31:0] s_axi_wdata = 32'h0;
  reg [3:0] s_axi_wstrb = 4'hF, drv_ready = 4'hF, dead = 4'h0, ecode = 4'h0;
  reg s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  reg [1:0] fails = 2'h0, br, rr;
  reg slow = 1'b0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire mem_req, mem_we, mem_ack, xfer_go, xfer_done, xfer_err;
  wire [15:0] mem_addr, xfer_addr;
  wire [7:0] mem_wdata, mem_rdata, xfer_fmt, xfer_track, xfer_sector;
  wire [3:0] drv_restore, drv_trk0, xfer_cmd, xfer_drv, xfer_code;
  int err_total = 0, tests_run = 0, i, k;
  logic [32:0] q[$];
  reg [31:0] rv, seed = 32'hDFEF;
  reg [15:0] pb [0:15];
  reg [47:0] tb [0:10];
  reg [3:0] m, wp;
  reg [7:0] t;
  reg [31:0] ev;
  reg [23:0] xe = 24'h0;
  dci_top #(.RESTORE_CYC(50)) dci_top_inst (.ref_clk, .sys_rst, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .mem_req, .mem_we, .mem_addr,
    .mem_wdata, .mem_rdata, .mem_ack, .drv_restore, .drv_trk0, .drv_ready, .xfer_go, .xfer_cmd,
    .xfer_drv, .xfer_fmt, .xfer_track, .xfer_sector, .xfer_addr, .xfer_done, .xfer_err,
    .xfer_code);
  dci_far_model dci_far_model_inst (.ref_clk, .sys_rst, .mem_req, .mem_we, .mem_addr,
    .mem_wdata, .mem_rdata, .mem_ack, .drv_restore, .drv_trk0, .dead, .xfer_go, .xfer_drv,
    .xfer_done, .xfer_err, .xfer_code, .fails, .ecode, .slow);
  initial begin
    forever #25 ref_clk = ~ref_clk;
  end
  function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task summarize;
    $display("comparisons %0d errors %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // ---------------------------------------------
  // register bus master
  // ---------------------------------------------
  task axw(input [7:0] a, input [31:0] d);
    reg ta, tw, b;
    int n;
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= !slow;
    b = 1'b0;
    for (n = 0; n < 200 && !b; n++) begin
      @(negedge ref_clk);
      {ta, tw, b, br} = {s_axi_awready, s_axi_wready, s_axi_bvalid & s_axi_bready, s_axi_bresp};
      @(posedge ref_clk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (b) s_axi_bready <= 1'b0;
      else if (s_axi_bvalid) s_axi_bready <= 1'b1;
    end
    if (!b) err_total++;
  endtask
  task axr(input [7:0] a, input [32:0] e);
    reg ta, b;
    int n;
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= !slow;
    q.push_back(e);
    b = 1'b0;
    for (n = 0; n < 200 && !b; n++) begin
      @(negedge ref_clk);
      {ta, b, rv, rr} = {s_axi_arready, s_axi_rvalid & s_axi_rready, s_axi_rdata, s_axi_rresp};
      @(posedge ref_clk);
      if (ta) s_axi_arvalid <= 1'b0;
      if (b) s_axi_rready <= 1'b0;
      else if (s_axi_rvalid) s_axi_rready <= 1'b1;
    end
    if (!b) err_total++;
  endtask
  // checking side: oldest note against each read result, compared only when its bit 32 is set
  always @(posedge ref_clk) begin
    if (s_axi_rvalid && s_axi_rready && q.size() > 0) begin
      ev = q[0][31:0];
      if (q.pop_front() >> 32) `CHK(s_axi_rdata, ev)
    end
    if (xfer_go) `CHK({xfer_cmd, xfer_drv, xfer_fmt, xfer_track}, xe)
  end
  task run(input [7:0] c, input [7:0] st);
    int n;
    axw(8'h00, {24'h0, c});
    for (n = 0; n < 300; n++) begin
      axr(8'h04, 33'h0);
      if (rv[9] === 1'b0) break;
    end
    axr(8'h04, {1'b1, 23'h0, st[7], st});
  endtask
  task ex(input [47:0] e);
    reg [15:0] b;
    b = pb[5];
    xe = e[47:24];
    dci_far_model_inst.mem[b + 16'h5] = 8'h00;
    dci_far_model_inst.mem[b] = e[47:40];
    dci_far_model_inst.mem[b + 16'h1] = 8'h00;
    dci_far_model_inst.mem[b + 16'h2] = e[39:32];
    dci_far_model_inst.mem[b + 16'h3] = e[31:24];
    dci_far_model_inst.mem[b + 16'h4] = e[23:16];
    dci_far_model_inst.mem[b + 16'h6] = e[15:8];
    run(8'h05, e[7:0]);
    `CHK(dci_far_model_inst.mem[b + 16'h1], e[7:0])
  endtask
  // ---------------------------------------------
  // test sequence
  // ---------------------------------------------
  initial begin
    tb[0] = 48'h01_00_05_05_00_C4; tb[1] = 48'h61_00_05_05_00_C4;
    tb[2] = 48'h20_00_05_05_00_C2; tb[3] = 48'h23_00_05_05_00_C3;
    tb[4] = 48'h21_00_4D_05_00_C5; tb[5] = 48'h21_00_05_00_00_C6;
    tb[6] = 48'h41_00_05_1B_00_C6; tb[7] = 48'h11_00_05_05_E0_C7;
    tb[8] = 48'h21_00_05_05_10_A1; tb[9] = 48'h12_00_05_05_10_A3;
    tb[10] = 48'h31_00_07_00_00_01;
    repeat (16) @(posedge ref_clk);
    sys_rst <= 1'b0;
    for (i = 0; i < 16; i++) begin
      pb[i] = (i == 0) ? 16'h0080 : {i[3:0], 12'h000};
      axr(8'h40 + 8'(4 * i), {17'h10000, pb[i]});
    end
    axr(8'h08, 33'h100000000);
    axr(8'h10, 33'h100000000);
    `CHK(rr, 2'h2)
    axw(8'h04, 32'h0);
    `CHK(br, 2'h2)
    for (k = 0; k < 3; k++) begin
      seed = lfsr(lfsr(lfsr(seed)));
      i = seed[19:16];
      pb[i] = {1'b0, seed[14:0]};
      axw(8'h00, {24'h0, 4'h1, i[3:0]});
      axw(8'h00, {24'h0, pb[i][7:0]});
      run(pb[i][15:8], 8'h01);
      axr(8'h40 + 8'(4 * i), {17'h10000, pb[i]});
    end
    wp = 4'h0;
    for (k = 0; k < 4; k++) begin
      seed = lfsr(seed);
      m = (seed[3:0] == 4'h0) ? 4'h1 : seed[3:0];
      wp = k[0] ? (wp & ~m) : (wp | m);
      run({k[0] ? 4'h4 : 4'h3, m}, 8'h01);
      axr(8'h08, {29'h10000000, wp});
    end
    for (k = 2; k < 7; k++) run({k[3:0], 4'h0}, (k < 5) ? 8'hC2 : 8'hC4);
    run(8'h4F, 8'h01);
    run(8'h32, 8'h01);
    seed = lfsr(seed);
    t = 8'(seed[7:0] % 76) + 8'h1;
    ex({8'h21, 8'h00, t, 24'h05_00_01});
    axr(8'h0C, {25'h1000000, t});
    run(8'h21, 8'h01);
    axr(8'h0C, 33'h100000000);
    dead <= 4'h4;
    run(8'h24, 8'h91);
    dead <= 4'h0;
    for (k = 0; k < 11; k++) begin
      slow <= k[0];
      drv_ready <= (k == 8) ? 4'hE : 4'hF;
      repeat (8) @(posedge ref_clk);
      ex(tb[k]);
    end
    fails <= 2'h1;
    ex(48'h51_00_09_03_00_01);
    seed = lfsr(seed);
    ecode <= 4'(seed[2:0]) + 4'h1;
    fails <= 2'h2;
    @(posedge ref_clk);
    ex({40'h22_00_0A_03_00, 4'h9, ecode});
    summarize;
  end
  initial begin
    repeat (60000) @(posedge ref_clk);
    err_total++;
    summarize;
  end
endmodule
